// *** hw/acd_pkg.sv ***
// Constants, register map and ratio tables for the audio clock divider and PLL control block
package acd_pkg;
    localparam int ACD_AW = 8;
    localparam int ACD_DW = 16;
    localparam int ACD_HW = 7;
    localparam int ACD_TOW = 22;
    // Register offsets
    localparam logic [7:0] ACD_OFS_POWER = 8'h02;
    localparam logic [7:0] ACD_OFS_CLKDIV = 8'h06;
    localparam logic [7:0] ACD_OFS_RATE = 8'h0a;
    localparam logic [7:0] ACD_OFS_PLL = 8'h3c;
    localparam logic [7:0] ACD_OFS_FRAC_HI = 8'h3d;
    localparam logic [7:0] ACD_OFS_FRAC_LO = 8'h3e;
    // Field positions
    localparam int ACD_B_PLL_EN = 15;
    localparam int ACD_B_PIN_EN = 11;
    localparam int ACD_B_TO_RATE = 15;
    localparam int ACD_B_TO_EN = 14;
    localparam int ACD_B_PINDIV_LO = 9;
    localparam int ACD_B_BCLKDIV_LO = 1;
    localparam int ACD_B_FRAME = 10;
    localparam int ACD_B_FRAC_MODE = 7;
    localparam int ACD_B_HALVE = 6;
    localparam int ACD_B_INT_LO = 0;
    // Reset values
    localparam logic [3:0] ACD_BCLKDIV_RST = 4'h4;
    localparam logic [3:0] ACD_PINDIV_RST = 4'h0;
    localparam logic [3:0] ACD_INT_RST = 4'h8;
    localparam logic [7:0] ACD_FRAC_HI_RST = 8'h31;
    localparam logic [7:0] ACD_FRAC_LO_RST = 8'h26;
    localparam logic [15:0] ACD_ZERO16 = 16'h0000;
    // System clocks per sample
    localparam logic [8:0] ACD_SPS_NORMAL = 9'h100;
    localparam logic [8:0] ACD_SPS_USB = 9'h110;
    // Pre-divider codes
    localparam logic [1:0] ACD_PREDIV_1 = 2'h0;
    localparam logic [1:0] ACD_PREDIV_2 = 2'h2;
    // Timeout dividers
    localparam int unsigned ACD_TO_SLOW_DIV = 32'h0020_0000;
    localparam int unsigned ACD_TO_FAST_DIV = 32'h0008_0000;

    // Ratios are held as twice the divide value so 1.5 and 5.5 stay integral
    function automatic logic [ACD_HW-1:0] acd_bclk_half(input logic [3:0] code);
        logic [ACD_HW-1:0] h;
        h = 7'h00;
        unique case (code)
            4'h0: h = 7'h02;
            4'h1: h = 7'h03;
            4'h2: h = 7'h04;
            4'h3: h = 7'h06;
            4'h4: h = 7'h08;
            4'h5: h = 7'h0b;
            4'h6: h = 7'h0c;
            4'h7: h = 7'h10;
            4'h8: h = 7'h16;
            4'h9: h = 7'h18;
            4'ha: h = 7'h20;
            4'hb: h = 7'h2c;
            4'hc: h = 7'h30;
            4'hd: h = 7'h40;
            4'he: h = 7'h58;
            4'hf: h = 7'h60;
        endcase
        return h;
    endfunction

    // Reserved codes give zero, which stops the pin clock
    function automatic logic [ACD_HW-1:0] acd_pin_half(input logic [3:0] code);
        logic [ACD_HW-1:0] h;
        h = 7'h00;
        case (code)
            4'h0: h = 7'h02;
            4'h1: h = 7'h04;
            4'h2: h = 7'h06;
            4'h3: h = 7'h08;
            4'h4: h = 7'h0b;
            4'h5: h = 7'h0c;
            4'h6: h = 7'h10;
            4'h7: h = 7'h18;
            4'h8: h = 7'h20;
            default: h = 7'h00;
        endcase
        return h;
    endfunction

    typedef enum logic {
        ACD_DIV_IDLE = 1'b0,
        ACD_DIV_RUN = 1'b1
    } acd_div_state_t;
endpackage

// *** hw/acd_div_if.sv ***
// Control and output signals of one fractional clock divider
interface acd_div_if;
    logic en;
    logic [6:0] half;
    logic tick;
    logic level;
    modport ctl (output en, output half, input tick, input level);
    modport div (input en, input half, output tick, output level);
endinterface

// *** hw/acd_frac_div.sv ***
// Fractional clock divider producing a tick and a clock level
module acd_frac_div (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control and output
    acd_div_if.div d
);
    import acd_pkg::*;

    acd_div_state_t state_q, state_d;
    logic [ACD_HW-1:0] cnt_q, cnt_d;
    logic [ACD_HW-1:0] len_q, len_d;
    logic [ACD_HW-1:0] half_q, half_d;
    logic phase_q, phase_d;
    logic tick_q, tick_d;
    logic level_q, level_d;
    logic boundary;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 7'h01;
        len_d = len_q;
        half_d = half_q;
        phase_d = phase_q;
        boundary = (state_q == ACD_DIV_IDLE) || (cnt_q == len_q - 7'h01);
        if (boundary) begin
            cnt_d = 7'h00;
            if (d.en && d.half != 7'h00) begin
                state_d = ACD_DIV_RUN;
                half_d = d.half;
                phase_d = ~phase_q;
                len_d = (d.half >> 1) + {6'h00, d.half[0] & phase_d};
            end else begin
                state_d = ACD_DIV_IDLE;
            end
        end
        tick_d = (state_d == ACD_DIV_RUN) && boundary;
        level_d = (state_d == ACD_DIV_RUN) && (cnt_d < ((len_d + 7'h01) >> 1));
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ACD_DIV_IDLE;
            cnt_q <= 7'h00;
            len_q <= 7'h01;
            half_q <= 7'h00;
            phase_q <= 1'b0;
            tick_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            half_q <= half_d;
            phase_q <= phase_d;
            tick_q <= tick_d;
            level_q <= level_d;
        end
    end

    assign d.tick = tick_q;
    assign d.level = level_q;

    // Helper: cycles since the last tick and the length then started
    logic [ACD_HW-1:0] gap_q, rec_len_q, prev_len_q, rec_half_q, prev_half_q;
    logic seen_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gap_q <= 7'h00;
            rec_len_q <= 7'h00;
            prev_len_q <= 7'h00;
            rec_half_q <= 7'h00;
            prev_half_q <= 7'h00;
            seen_q <= 1'b0;
        end else if (tick_q) begin
            gap_q <= 7'h01;
            rec_len_q <= len_q;
            prev_len_q <= rec_len_q;
            rec_half_q <= half_q;
            prev_half_q <= rec_half_q;
            seen_q <= 1'b1;
        end else if (state_q == ACD_DIV_IDLE) begin
            // A stop breaks the chain of periods, so the next tick starts afresh
            gap_q <= 7'h00;
            seen_q <= 1'b0;
        end else begin
            gap_q <= gap_q + 7'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_tick_gap: assert property (tick_q && seen_q |-> gap_q == rec_len_q)
        else $error("divider period differs from the latched length");
    // Both periods must come from the same ratio, or a code change looks like a bad average
    a_frac_avg: assert property (tick_q && seen_q && rec_half_q[0] && rec_half_q == prev_half_q
        && rec_len_q != prev_len_q |-> rec_len_q + prev_len_q == rec_half_q)
        else $error("half-integer periods do not average to the ratio");
    a_level_hold: assert property (state_q == ACD_DIV_RUN && !boundary |=> $stable(len_q))
        else $error("period length changed inside a period");
    c_odd_ratio: cover property (tick_q && half_q == 7'h03 ##[1:4] tick_q);
endmodule // acd_frac_div

// *** hw/acd_clkgen.sv ***
// Clock divider and PLL control registers for the audio ADC
module acd_clkgen #(
    parameter int unsigned TO_SLOW_DIV = acd_pkg::ACD_TO_SLOW_DIV,
    parameter int unsigned TO_FAST_DIV = acd_pkg::ACD_TO_FAST_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [acd_pkg::ACD_AW-1:0] reg_addr,
    input wire logic [acd_pkg::ACD_DW-1:0] reg_wdata,
    output logic [acd_pkg::ACD_DW-1:0] reg_rdata_q,
    output logic reg_rvalid_q,
    // Bit clock pin
    input wire logic master_mode,
    input wire logic bit_clock_i,
    output logic bit_clock_o_q,
    output logic bit_clock_oe_n_q,
    output logic bit_clock_in_q,
    output logic bit_clock_tick_q,
    // Pin clock
    input wire logic [2:0] pin_clock_permit,
    output logic [2:0] pin_clock_output_q,
    // Timeout clock enable pulse
    output logic timeout_clock_q,
    // System clock and PLL
    input wire logic [1:0] system_clock_prediv,
    output logic system_clock_halve_q,
    output logic frame_rate_mode_q,
    output logic [8:0] system_clock_per_sample_q,
    output logic pll_enable_q,
    output logic pll_input_halve_q,
    output logic [3:0] pll_integer_part_q,
    output logic pll_fractional_mode_q,
    output logic [15:0] pll_fraction_part_q
);
    import acd_pkg::*;

    localparam logic [ACD_TOW-1:0] TO_SLOW_LAST = ACD_TOW'(TO_SLOW_DIV - 1);
    localparam logic [ACD_TOW-1:0] TO_FAST_LAST = ACD_TOW'(TO_FAST_DIV - 1);

    // Register file
    logic pin_en_q, pin_en_d;
    logic to_rate_q, to_rate_d;
    logic to_en_q, to_en_d;
    logic [3:0] pin_div_q, pin_div_d;
    logic [3:0] bclk_div_q, bclk_div_d;
    logic frame_q, frame_d;
    logic pll_en_d, halve_d, frac_mode_d;
    logic [3:0] int_d;
    logic [7:0] frac_hi_q, frac_hi_d, frac_lo_q, frac_lo_d;
    logic [ACD_DW-1:0] rdata_d;

    always_comb begin
        pin_en_d = pin_en_q;
        to_rate_d = to_rate_q;
        to_en_d = to_en_q;
        pin_div_d = pin_div_q;
        bclk_div_d = bclk_div_q;
        frame_d = frame_q;
        pll_en_d = pll_enable_q;
        halve_d = pll_input_halve_q;
        frac_mode_d = pll_fractional_mode_q;
        int_d = pll_integer_part_q;
        frac_hi_d = frac_hi_q;
        frac_lo_d = frac_lo_q;
        if (reg_wr) begin
            case (reg_addr)
                ACD_OFS_POWER: begin
                    pll_en_d = reg_wdata[ACD_B_PLL_EN];
                    pin_en_d = reg_wdata[ACD_B_PIN_EN];
                end
                ACD_OFS_CLKDIV: begin
                    to_rate_d = reg_wdata[ACD_B_TO_RATE];
                    to_en_d = reg_wdata[ACD_B_TO_EN];
                    pin_div_d = reg_wdata[ACD_B_PINDIV_LO +: 4];
                    bclk_div_d = reg_wdata[ACD_B_BCLKDIV_LO +: 4];
                end
                ACD_OFS_RATE: frame_d = reg_wdata[ACD_B_FRAME];
                ACD_OFS_PLL: begin
                    frac_mode_d = reg_wdata[ACD_B_FRAC_MODE];
                    halve_d = reg_wdata[ACD_B_HALVE];
                    int_d = reg_wdata[ACD_B_INT_LO +: 4];
                end
                ACD_OFS_FRAC_HI: frac_hi_d = reg_wdata[7:0];
                ACD_OFS_FRAC_LO: frac_lo_d = reg_wdata[7:0];
                default: ;
            endcase
        end
        rdata_d = ACD_ZERO16;
        case (reg_addr)
            ACD_OFS_POWER: begin
                rdata_d[ACD_B_PLL_EN] = pll_enable_q;
                rdata_d[ACD_B_PIN_EN] = pin_en_q;
            end
            ACD_OFS_CLKDIV: begin
                rdata_d[ACD_B_TO_RATE] = to_rate_q;
                rdata_d[ACD_B_TO_EN] = to_en_q;
                rdata_d[ACD_B_PINDIV_LO +: 4] = pin_div_q;
                rdata_d[ACD_B_BCLKDIV_LO +: 4] = bclk_div_q;
            end
            ACD_OFS_RATE: rdata_d[ACD_B_FRAME] = frame_q;
            ACD_OFS_PLL: begin
                rdata_d[ACD_B_FRAC_MODE] = pll_fractional_mode_q;
                rdata_d[ACD_B_HALVE] = pll_input_halve_q;
                rdata_d[ACD_B_INT_LO +: 4] = pll_integer_part_q;
            end
            ACD_OFS_FRAC_HI: rdata_d[7:0] = frac_hi_q;
            ACD_OFS_FRAC_LO: rdata_d[7:0] = frac_lo_q;
            default: ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_en_q <= 1'b0;
            to_rate_q <= 1'b0;
            to_en_q <= 1'b0;
            pin_div_q <= ACD_PINDIV_RST;
            bclk_div_q <= ACD_BCLKDIV_RST;
            frame_q <= 1'b0;
            pll_enable_q <= 1'b0;
            pll_input_halve_q <= 1'b0;
            pll_fractional_mode_q <= 1'b0;
            pll_integer_part_q <= ACD_INT_RST;
            frac_hi_q <= ACD_FRAC_HI_RST;
            frac_lo_q <= ACD_FRAC_LO_RST;
            reg_rdata_q <= ACD_ZERO16;
            reg_rvalid_q <= 1'b0;
        end else begin
            pin_en_q <= pin_en_d;
            to_rate_q <= to_rate_d;
            to_en_q <= to_en_d;
            pin_div_q <= pin_div_d;
            bclk_div_q <= bclk_div_d;
            frame_q <= frame_d;
            pll_enable_q <= pll_en_d;
            pll_input_halve_q <= halve_d;
            pll_fractional_mode_q <= frac_mode_d;
            pll_integer_part_q <= int_d;
            frac_hi_q <= frac_hi_d;
            frac_lo_q <= frac_lo_d;
            reg_rdata_q <= reg_rd ? rdata_d : reg_rdata_q;
            reg_rvalid_q <= reg_rd;
        end
    end

    // Bit clock and pin clock dividers
    acd_div_if d_bclk ();
    acd_div_if d_pin ();
    assign d_bclk.en = master_mode;
    assign d_bclk.half = acd_bclk_half(bclk_div_q);
    assign d_pin.en = pin_en_q;
    assign d_pin.half = acd_pin_half(pin_div_q);

    acd_frac_div u_bclk_div (.clk(clk), .rst_n(rst_n), .d(d_bclk));
    acd_frac_div u_pin_div (.clk(clk), .rst_n(rst_n), .d(d_pin));

    // Timeout divider; the rate is taken only at wrap or while disabled, so a change never shortens a period
    logic [ACD_TOW-1:0] to_cnt_q, to_cnt_d;
    logic to_fast_q, to_fast_d;
    logic to_tick_d;
    always_comb begin
        to_cnt_d = to_cnt_q + 22'h00_0001;
        to_fast_d = to_fast_q;
        to_tick_d = 1'b0;
        if (!to_en_q) begin
            to_cnt_d = '0;
            to_fast_d = to_rate_q;
        end else if (to_cnt_q == (to_fast_q ? TO_FAST_LAST : TO_SLOW_LAST)) begin
            to_cnt_d = '0;
            to_fast_d = to_rate_q;
            to_tick_d = 1'b1;
        end
    end

    // Pin outputs; the bit clock input only passes a three-stage synchroniser
    logic bclk_meta_q, bclk_sync_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            to_cnt_q <= '0;
            to_fast_q <= 1'b0;
            timeout_clock_q <= 1'b0;
            bclk_meta_q <= 1'b0;
            bclk_sync_q <= 1'b0;
            bit_clock_in_q <= 1'b0;
            bit_clock_o_q <= 1'b0;
            bit_clock_oe_n_q <= 1'b1;
            bit_clock_tick_q <= 1'b0;
            pin_clock_output_q <= 3'h0;
            system_clock_halve_q <= 1'b0;
            frame_rate_mode_q <= 1'b0;
            system_clock_per_sample_q <= ACD_SPS_NORMAL;
            pll_fraction_part_q <= ACD_ZERO16;
        end else begin
            to_cnt_q <= to_cnt_d;
            to_fast_q <= to_fast_d;
            timeout_clock_q <= to_tick_d;
            bclk_meta_q <= bit_clock_i;
            bclk_sync_q <= bclk_meta_q;
            bit_clock_in_q <= bclk_sync_q;
            bit_clock_o_q <= master_mode & d_bclk.level;
            bit_clock_oe_n_q <= ~master_mode;
            bit_clock_tick_q <= master_mode & d_bclk.tick;
            pin_clock_output_q <= {3{d_pin.level}} & pin_clock_permit;
            if (system_clock_prediv == ACD_PREDIV_1) begin
                system_clock_halve_q <= 1'b0;
            end else if (system_clock_prediv == ACD_PREDIV_2) begin
                system_clock_halve_q <= 1'b1;
            end
            frame_rate_mode_q <= frame_q;
            system_clock_per_sample_q <= frame_q ? ACD_SPS_USB : ACD_SPS_NORMAL;
            pll_fraction_part_q <= pll_fractional_mode_q ? {frac_hi_q, frac_lo_q} : ACD_ZERO16;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_reset_values: assert property (disable iff (1'b0) !rst_n |=> pll_integer_part_q == ACD_INT_RST
        && !pll_enable_q && !pll_fractional_mode_q && !pll_input_halve_q && bclk_div_q == ACD_BCLKDIV_RST)
        else $error("control fields not at reset values");
    a_slave_release: assert property (!master_mode |=> bit_clock_oe_n_q && !bit_clock_o_q ##1 !bit_clock_tick_q)
        else $error("bit clock driven in slave mode");
    a_frac_gate: assert property (pll_fraction_part_q != ACD_ZERO16 |-> $past(pll_fractional_mode_q))
        else $error("fraction applied in integer mode");
    // Enable is taken at the period boundary, so it is checked on the first high cycle of a period only
    a_pin_gate: assert property (pin_clock_output_q != 3'h0 |->
        (pin_clock_output_q & ~$past(pin_clock_permit)) == 3'h0
        && (!$past(d_pin.tick) || $past(pin_en_q, 2)))
        else $error("pin clock driven without enable or permission");
    a_frame_rate: assert property (frame_q |=> system_clock_per_sample_q == ACD_SPS_USB ##0 frame_rate_mode_q)
        else $error("frame rate mode not reflected");
    a_timeout_wrap: assert property (timeout_clock_q |-> $past(to_en_q)
        && $past(to_cnt_q) == ($past(to_fast_q) ? TO_FAST_LAST : TO_SLOW_LAST))
        else $error("timeout tick at wrong count");
    a_timeout_off: assert property (!to_en_q ##1 !to_en_q |-> !timeout_clock_q)
        else $error("timeout tick while disabled");
    a_prediv_half: assert property (system_clock_prediv == ACD_PREDIV_2 |=> system_clock_halve_q)
        else $error("pre-divider by two not applied");
    a_pll_enable: assert property (reg_wr && reg_addr == ACD_OFS_POWER |=>
        pll_enable_q == $past(reg_wdata[ACD_B_PLL_EN]))
        else $error("PLL enable not written");

    c_master_tick: cover property (master_mode && bit_clock_tick_q);
    c_pin_clock: cover property (pin_clock_output_q != 3'h0);
    c_timeout: cover property (timeout_clock_q && to_fast_q);
    c_usb_mode: cover property (frame_rate_mode_q && !pll_enable_q);
endmodule // acd_clkgen

// *** verif/acd_host_model.sv ***
// Behavioural host processor that drives the bit clock pin in slave mode
module acd_host_model #(
    parameter int HALF = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bit clock drive
    input wire logic run,
    output logic bit_clock = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt_q = 0;
    // Stands still between frames instead of running free
    always @(posedge clk) begin
        if (!rst_n || !run) begin
            cnt_q <= 0;
            bit_clock <= 1'b0;
        end else if (cnt_q == HALF - 1) begin
            cnt_q <= 0;
            bit_clock <= ~bit_clock;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule // acd_host_model

// *** verif/tb_acd_clkgen.sv ***
// Self-checking testbench for the clock divider and PLL control block
module tb_acd_clkgen;
    timeunit 1ns;
    timeprecision 100ps;
    import acd_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic master_mode = 1'b0;
    logic host_run = 1'b0;
    logic [2:0] pin_clock_permit = 3'h0;
    logic [1:0] system_clock_prediv = 2'h0;
    logic host_clk, pin_level, reg_rvalid_q, bit_clock_o_q, bit_clock_oe_n_q, bit_clock_in_q, bit_clock_tick_q;
    logic timeout_clock_q, system_clock_halve_q, frame_rate_mode_q, pll_enable_q, pll_input_halve_q, pll_fractional_mode_q;
    logic [15:0] reg_rdata_q, pll_fraction_part_q;
    logic [2:0] pin_clock_output_q;
    logic [8:0] system_clock_per_sample_q;
    logic [3:0] pll_integer_part_q;
    int n_fail = 0;
    int samples_checked = 0;
    int bhalf [16] = '{2, 3, 4, 6, 8, 11, 12, 16, 22, 24, 32, 44, 48, 64, 88, 96};
    int phalf [9] = '{2, 4, 6, 8, 11, 12, 16, 24, 32};

    always #5 clk = ~clk;
    // The pin carries the device while it drives, the host otherwise
    assign pin_level = bit_clock_oe_n_q ? host_clk : bit_clock_o_q;

    acd_clkgen #(.TO_SLOW_DIV(64), .TO_FAST_DIV(16)) i_acd_clkgen (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .master_mode, .bit_clock_i(pin_level), .bit_clock_o_q,
        .bit_clock_oe_n_q, .bit_clock_in_q, .bit_clock_tick_q, .pin_clock_permit, .pin_clock_output_q,
        .timeout_clock_q, .system_clock_prediv, .system_clock_halve_q, .frame_rate_mode_q, .system_clock_per_sample_q,
        .pll_enable_q, .pll_input_halve_q, .pll_integer_part_q, .pll_fractional_mode_q, .pll_fraction_part_q);
    acd_host_model #(.HALF(5)) i_acd_host_model (.clk, .rst_n, .run(host_run), .bit_clock(host_clk));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick2();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        chk(reg_rvalid_q, 1);
        chk(reg_rdata_q, e);
    endtask

    // Pulses count when high, clock levels only on a rising edge
    function automatic logic probe(input int s);
        case (s)
            0: return bit_clock_tick_q;
            1: return pin_clock_output_q[0];
            2: return timeout_clock_q;
            default: return bit_clock_in_q;
        endcase
    endfunction

    task automatic cnt(input int s, input int len, output int n);
        logic prev;
        logic cur;
        n = 0;
        prev = probe(s);
        repeat (len) begin
            @(posedge clk);
            #1;
            cur = probe(s);
            if (cur && (s == 0 || s == 2 || !prev)) n++;
            prev = cur;
        end
    endtask

    task automatic gap(input int s, output int n);
        logic prev;
        logic cur;
        prev = probe(s);
        for (n = 1; n < 400; n++) begin
            @(posedge clk);
            #1;
            cur = probe(s);
            if (cur && (s == 0 || s == 2 || !prev)) return;
            prev = cur;
        end
        n_fail++;
        tally_and_finish();
    endtask

    // The first periods after a write may still run on the old code
    task automatic per2(input int s, input int half);
        int a;
        int b;
        gap(s, a);
        gap(s, a);
        gap(s, a);
        gap(s, b);
        chk(a + b, half);
    endtask

    initial begin
        int n;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rd(ACD_OFS_CLKDIV, 16'h0008);
        rd(ACD_OFS_POWER, 16'h0000);
        rd(ACD_OFS_RATE, 16'h0000);
        rd(ACD_OFS_PLL, 16'h0008);
        rd(ACD_OFS_FRAC_HI, 16'h0031);
        rd(ACD_OFS_FRAC_LO, 16'h0026);
        wr(8'h07, 16'hffff);
        rd(8'h07, 16'h0000);
        chk(pll_fraction_part_q, 16'h0000);
        master_mode = 1'b1;
        tick2();
        chk(bit_clock_oe_n_q, 0);
        per2(0, 8);
        cnt(3, 40, n);
        chk(n, 10);
        for (int c = 1; c < 16; c++) begin
            wr(ACD_OFS_CLKDIV, 16'(c << 1));
            per2(0, bhalf[c]);
        end
        wr(ACD_OFS_CLKDIV, 16'h0000);
        per2(0, 2);
        cnt(0, 8, n);
        chk(n, 8);
        pin_clock_permit = 3'b101;
        wr(ACD_OFS_POWER, 16'h0800);
        for (int c = 1; c < 9; c++) begin
            wr(ACD_OFS_CLKDIV, 16'(c << 9));
            per2(1, phalf[c]);
            chk(pin_clock_output_q[1], 0);
        end
        wr(ACD_OFS_CLKDIV, 16'h1200);
        cnt(1, 80, n);
        cnt(1, 40, n);
        chk({n[3:0], pin_clock_output_q}, 0);
        wr(ACD_OFS_CLKDIV, 16'h0600);
        wr(ACD_OFS_POWER, 16'h0000);
        cnt(1, 40, n);
        cnt(1, 40, n);
        chk(n, 0);
        wr(ACD_OFS_CLKDIV, 16'h4000);
        gap(2, n);
        gap(2, n);
        chk(n, 64);
        wr(ACD_OFS_CLKDIV, 16'hc000);
        gap(2, n);
        gap(2, n);
        chk(n, 16);
        wr(ACD_OFS_CLKDIV, 16'h0000);
        cnt(2, 80, n);
        chk(n, 0);
        wr(ACD_OFS_RATE, 16'h0400);
        tick2();
        chk({frame_rate_mode_q, system_clock_per_sample_q}, {1'b1, ACD_SPS_USB});
        rd(ACD_OFS_RATE, 16'h0400);
        wr(ACD_OFS_RATE, 16'h0000);
        tick2();
        chk(system_clock_per_sample_q, ACD_SPS_NORMAL);
        wr(ACD_OFS_POWER, 16'h8000);
        wr(ACD_OFS_PLL, 16'h00c7);
        wr(ACD_OFS_FRAC_HI, 16'h0086);
        wr(ACD_OFS_FRAC_LO, 16'h00c2);
        tick2();
        chk({pll_enable_q, pll_input_halve_q, pll_fractional_mode_q, pll_integer_part_q}, 7'h77);
        chk(pll_fraction_part_q, 16'h86c2);
        wr(ACD_OFS_PLL, 16'h0009);
        wr(ACD_OFS_POWER, 16'h0000);
        tick2();
        chk({pll_enable_q, pll_input_halve_q, pll_fraction_part_q, pll_integer_part_q}, 22'h9);
        rd(ACD_OFS_PLL, 16'h0009);
        rd(ACD_OFS_FRAC_HI, 16'h0086);
        system_clock_prediv = 2'h2;
        tick2();
        chk(system_clock_halve_q, 1);
        system_clock_prediv = 2'h1;
        tick2();
        chk(system_clock_halve_q, 1);
        system_clock_prediv = 2'h0;
        tick2();
        chk(system_clock_halve_q, 0);
        master_mode = 1'b0;
        host_run = 1'b1;
        tick2();
        chk({bit_clock_oe_n_q, bit_clock_o_q}, 2'b10);
        cnt(3, 100, n);
        chk(n >= 9, 1);
        cnt(0, 50, n);
        chk(n, 0);
        tally_and_finish();
    end
endmodule // tb_acd_clkgen
